// File: bench/wdr_top_bench.sv
// Self-checking bench of the watchdog and reset-cause block
`timescale 1ns/1ps
module wdr_top_bench import wdr_pkg::*; ;
    // Shortened counts so that the run stays brief
    localparam int DIV = 4;
    localparam int SDLY = 8;
    localparam int QUAL = 10;
    // Clock, reset, strobes and supply
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clrWdtInstr = 1'b0, sleepInstr = 1'b0, wakeUp = 1'b0, lowSupply = 1'b0;
    logic sysRst, pcSpRst, irq;
    // Register bus
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int err_count = 0;
    int checks_done = 0;

    // Device under test
    wdr_top #(.LOW_SPEED_INTERNAL_OSCILLATOR_DIV(DIV), .SRESET_DLY(SDLY), .LVR_QUAL(QUAL)) u_wdr_top (
        .sys_clk, .arst_n, .clrWdtInstr, .sleepInstr, .wakeUp, .lowSupply, .sysRst, .pcSpRst, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // Free-running clock
    always #5 sys_clk = ~sys_clk;

    // Verdict and end of run
    task automatic end_of_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Comparison of one value
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // A wait that ran out ends the run
    task automatic timeout();
        err_count++;
        $display("mismatch at %0t: wait ran out", $time);
        end_of_test();
    endtask

    // Bus write, then compare the response code
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                s_axi_bready <= 1'b0;
                check({30'h0, s_axi_bresp}, {30'h0, er});
                break;
            end
        end
        if (n == 40) timeout();
    endtask

    // Bus read returning data and response
    task automatic peek(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 40) timeout();
    endtask

    // Bus read compared with expected data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        peek(a, d, r);
        check(d, ed);
        check({30'h0, r}, {30'h0, er});
    endtask

    // One-cycle strobe: 0 clear, 1 sleep, 2 wake
    task automatic strobe(input int k);
        @(posedge sys_clk);
        clrWdtInstr <= (k == 0);
        sleepInstr <= (k == 1);
        wakeUp <= (k == 2);
        @(posedge sys_clk);
        clrWdtInstr <= 1'b0;
        sleepInstr <= 1'b0;
        wakeUp <= 1'b0;
    endtask

    // Edges until a reset output is seen; n equals lim when none came
    task automatic wait_rst(input int lim, output int n, output logic sys);
        for (n = 1; n < lim; n++) begin
            @(posedge sys_clk);
            if (sysRst === 1'b1 || pcSpRst === 1'b1) break;
        end
        sys = sysRst;
    endtask

    // Bus access followed by a look at the interrupt line
    task automatic irq_step(input logic [7:0] a, input logic [31:0] v, input logic e);
        wr(a, v, RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq}, {31'h0, e});
    endtask

    // Main sequence
    initial begin
        int n;
        int exp;
        logic f;
        logic [31:0] d;
        logic [1:0] r;
        repeat (20) @(posedge sys_clk);
        check({31'h0, sysRst}, 32'h1);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // Values after power-on
        rd(OFF_CTRL, 32'h53, RESP_OKAY);
        rd(OFF_CAUSE, 32'h0, RESP_OKAY);
        rd(OFF_STAT, 32'h0, RESP_OKAY);
        // Second key runs the watchdog, key bits writable
        wr(OFF_CTRL, 32'hab, RESP_OKAY);
        rd(OFF_CTRL, 32'hab, RESP_OKAY);
        wait_rst(SDLY * 3, n, f);
        check(n, SDLY * 3);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'h5a, RESP_SLVERR);
        // Regular clearing keeps the shortest period from running out
        strobe(0);
        wr(OFF_CTRL, 32'h50, RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            strobe(0);
            wait_rst(700, n, f);
            check(n, 700);
        end
        // Timeout length for the three shortest period selections
        for (int s = 0; s < 3; s++) begin
            exp = (256 << (2 * s)) * DIV;
            strobe(0);
            wr(OFF_CTRL, {24'h0, KEY_A, 3'(s)}, RESP_OKAY);
            strobe(0);
            wait_rst(exp + 100, n, f);
            check({31'h0, f}, 32'h1);
            check({31'h0, n >= exp - DIV - 2 && n <= exp + DIV + 2}, 32'h1);
        end
        rd(OFF_CTRL, 32'h53, RESP_OKAY);
        rd(OFF_STAT, 32'h1, RESP_OKAY);
        rd(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
        irq_step(OFF_IRQ_EN, 32'h1, 1'b1);
        irq_step(OFF_IRQ_EN, 32'h0, 1'b0);
        irq_step(OFF_IRQ_EN, 32'h1, 1'b1);
        irq_step(OFF_IRQ_CLR, 32'h1, 1'b0);
        // Sleep entry, ignored low supply, then overflow while asleep
        strobe(0);
        wr(OFF_CTRL, 32'h50, RESP_OKAY);
        strobe(1);
        rd(OFF_STAT, 32'h6, RESP_OKAY);
        @(posedge sys_clk);
        lowSupply <= 1'b1;
        wait_rst(QUAL * 3, n, f);
        check(n, QUAL * 3);
        lowSupply <= 1'b0;
        wait_rst(1400, n, f);
        check({31'h0, f}, 32'h0);
        check({31'h0, n < 1400}, 32'h1);
        peek(OFF_STAT, d, r);
        check(d & 32'h3, 32'h3);
        strobe(2);
        strobe(0);
        peek(OFF_STAT, d, r);
        check(d & 32'h2, 32'h0);
        // Short low-supply pulse is ignored, a long one resets
        @(posedge sys_clk);
        lowSupply <= 1'b1;
        wait_rst(5, n, f);
        lowSupply <= 1'b0;
        wait_rst(QUAL + 5, n, f);
        check(n, QUAL + 5);
        @(posedge sys_clk);
        lowSupply <= 1'b1;
        wait_rst(QUAL + 20, n, f);
        lowSupply <= 1'b0;
        check({31'h0, f}, 32'h1);
        check({31'h0, n >= QUAL && n <= QUAL + 2}, 32'h1);
        rd(OFF_CAUSE, 32'h4, RESP_OKAY);
        wr(OFF_CAUSE, 32'h0, RESP_OKAY);
        rd(OFF_CAUSE, 32'h0, RESP_OKAY);
        // Bad key leads to a full reset after the delay
        strobe(0);
        wr(OFF_CTRL, 32'h00, RESP_OKAY);
        wait_rst(SDLY + 20, n, f);
        check({31'h0, f}, 32'h1);
        check({31'h0, n >= SDLY - 3 && n <= SDLY + 2}, 32'h1);
        rd(OFF_CAUSE, 32'h1, RESP_OKAY);
        rd(OFF_IRQ_STAT, 32'hf, RESP_OKAY);
        rd(OFF_CTRL, 32'h53, RESP_OKAY);
        wr(OFF_CAUSE, 32'hff, RESP_OKAY);
        rd(OFF_CAUSE, 32'h5, RESP_OKAY);
        wr(OFF_CAUSE, 32'h0, RESP_OKAY);
        rd(OFF_CAUSE, 32'h0, RESP_OKAY);
        end_of_test();
    end
endmodule // wdr_top_bench

// File: hw/wdr_axil.sv
// AXI4-Lite slave front end with a simple register port
`timescale 1ns/1ps
module wdr_axil import wdr_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // AXI4-Lite
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register port
    output logic wrEn,
    output wdr_regwr_t wrReq,
    input wire logic wrHit,
    output logic [7:0] rdAddr,
    input wire logic [31:0] rdData,
    input wire logic rdHit
);
    logic awHeld;
    logic wHeld;

    // Write commits once address and data are both held
    assign wrEn = awHeld && wHeld && !s_axi_bvalid;
    assign rdAddr = s_axi_araddr;

    // Write channels, taken in either order
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            wrReq <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                s_axi_awready <= 1'b0;
                wrReq.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                s_axi_wready <= 1'b0;
                wrReq.data <= s_axi_wdata;
                wrReq.strb <= s_axi_wstrb;
            end
            if (wrEn) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel, data captured at the address handshake
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdHit ? rdData : 32'h0000_0000;
            s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // wdr_axil

// File: hw/wdr_hold_timer.sv
// Persistence timer: one pulse once its input has stood high LIMIT cycles
`timescale 1ns/1ps
module wdr_hold_timer import wdr_pkg::*; #(
    parameter int LIMIT = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Condition and result
    input wire logic run,
    output logic done
);
    localparam int W = $clog2(LIMIT + 1);
    logic [W-1:0] cnt;

    if (LIMIT < 1) begin : g_chk
        $error("wdr_hold_timer: LIMIT must be at least 1");
    end

    // Counts while run holds, restarts when it drops, fires once
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cnt <= '0;
            done <= 1'b0;
        end else begin
            done <= run && (cnt == W'(LIMIT - 1));
            if (!run) begin
                cnt <= '0;
            end else if (cnt != W'(LIMIT)) begin
                cnt <= cnt + W'(1);
            end
        end
    end
endmodule // wdr_hold_timer

// File: hw/wdr_top.sv
// Watchdog timer with key control, reset generation and reset-cause flags
`timescale 1ns/1ps
// Summary of operation
// - Watchdog counts low-speed ticks made from the system clock by a divider
// - Period select picks 2^8,10,12,14,15,16,17,18 ticks as the timeout
// - Control holds key in bits 7..3 and period in bits 2..0, all RW
// - Watchdog runs while the key holds 01010 or 10101
// - Any other key gives a full chip reset after the software-reset delay
// - Control resets to 0x53, watchdog enabled
// - Key-mismatch reset sets cause bit 0; only software clears it
// - Overflow in normal run gives a full reset and sets timeout flag
// - Overflow while asleep sets timeout flag, resets only PC and stack
// - Counter cleared by key reset, clear instruction or sleep entry
// - Low-voltage reset only after low supply persists past qualify time
// - Low-voltage reset disabled while asleep or idle
// - Qualified low-voltage reset sets cause bit 2; only software clears
// - Cause bits 7..3 and 1 read as zero
// - Sleep entry sets power-down, clears timeout flag and counter
// - Power-down flag cleared by power-up or clear instruction
module wdr_top import wdr_pkg::*; #(
    parameter int LOW_SPEED_INTERNAL_OSCILLATOR_DIV = LOW_SPEED_INTERNAL_OSCILLATOR_DIV_CYC,
    parameter int SRESET_DLY = SRESET_CYC,
    parameter int LVR_QUAL = LVR_QUAL_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Core instruction strobes and wake
    input wire logic clrWdtInstr,
    input wire logic sleepInstr,
    input wire logic wakeUp,
    // Supply monitor
    input wire logic lowSupply,
    // Reset and interrupt outputs
    output logic sysRst,
    output logic pcSpRst,
    output logic irq,
    // AXI4-Lite
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int DIV_W = $clog2(LOW_SPEED_INTERNAL_OSCILLATOR_DIV);

    if (LOW_SPEED_INTERNAL_OSCILLATOR_DIV < 2 || SRESET_DLY < 1 || LVR_QUAL < 1) begin : g_chk
        $error("wdr_top: divider, delay and qualify counts out of range");
    end

    logic rstMeta;
    logic rstN;
    wdr_ctrl_t ctrl;
    logic [CNT_W-1:0] cnt;
    logic [DIV_W-1:0] divCnt;
    logic tick;
    logic key_mismatch_reset_flag;
    logic low_voltage_reset_flag;
    logic toFlag;
    logic power_down_flag;
    logic lowPower;
    logic [3:0] irqStat;
    logic [3:0] irqEn;
    logic [3:0] next_irqStat;
    logic wrEn;
    wdr_regwr_t wrReq;
    logic wrHit;
    logic [7:0] rdAddr;
    logic [31:0] rdData;
    logic rdHit;
    logic keyOk;
    logic mmDone;
    logic lvRun;
    logic lvDone;
    logic clrEvt;
    logic ovf;
    logic ovfRun;
    logic ovfSleep;
    logic fullRst;
    logic wrLane;

    // Valid key test, used for the live field
    function automatic logic keyValid(input logic [4:0] k);
        return (k == KEY_A) || (k == KEY_B);
    endfunction

    // Last count before overflow for each period code
    function automatic logic [CNT_W-1:0] lastCount(input logic [2:0] s);
        logic [CNT_W-1:0] v;
        v = '0;
        unique case (s)
            3'h0: v = 18'h000ff;
            3'h1: v = 18'h003ff;
            3'h2: v = 18'h00fff;
            3'h3: v = 18'h03fff;
            3'h4: v = 18'h07fff;
            3'h5: v = 18'h0ffff;
            3'h6: v = 18'h1ffff;
            3'h7: v = 18'h3ffff;
        endcase
        return v;
    endfunction

    // Register map decode, shared by reads and writes
    function automatic logic mapped(input logic [7:0] a);
        return a == OFF_CTRL || a == OFF_CAUSE || a == OFF_STAT
            || a == OFF_IRQ_STAT || a == OFF_IRQ_CLR || a == OFF_IRQ_EN;
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // Bus front end
    wdr_axil u_axil (
        .clk(sys_clk),
        .rstN(rstN),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wrEn(wrEn),
        .wrReq(wrReq),
        .wrHit(wrHit),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .rdHit(rdHit)
    );

    assign wrHit = mapped(wrReq.addr);
    assign rdHit = mapped(rdAddr);
    assign wrLane = wrEn && wrReq.strb[0];

    // Read mux, narrow registers in the low byte
    always_comb begin
        rdData = 32'h0000_0000;
        unique case (rdAddr)
            OFF_CTRL: rdData[7:0] = ctrl;
            OFF_CAUSE: rdData[7:0] = {5'h00, low_voltage_reset_flag, 1'b0, key_mismatch_reset_flag};
            OFF_STAT: rdData[2:0] = {lowPower, power_down_flag, toFlag};
            OFF_IRQ_STAT: rdData[3:0] = irqStat;
            OFF_IRQ_EN: rdData[3:0] = irqEn;
            default: rdData = 32'h0000_0000;
        endcase
    end

    // Low-speed tick divider
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            divCnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= divCnt == DIV_W'(LOW_SPEED_INTERNAL_OSCILLATOR_DIV - 1);
            divCnt <= (divCnt == DIV_W'(LOW_SPEED_INTERNAL_OSCILLATOR_DIV - 1)) ? '0 : divCnt + DIV_W'(1);
        end
    end

    // Key check and software-reset delay
    assign keyOk = keyValid(ctrl.key);
    wdr_hold_timer #(.LIMIT(SRESET_DLY)) u_keyDly (
        .clk(sys_clk),
        .rstN(rstN),
        .run(!keyOk && !fullRst),
        .done(mmDone)
    );

    // Low-supply persistence, off while asleep or idle
    assign lvRun = lowSupply && !lowPower && !fullRst;
    wdr_hold_timer #(.LIMIT(LVR_QUAL)) u_lvQual (
        .clk(sys_clk),
        .rstN(rstN),
        .run(lvRun),
        .done(lvDone)
    );

    // Overflow detection, clear events win over the last tick
    // Mask compare, so a period shortened mid-count still ends within its own length
    assign clrEvt = clrWdtInstr || sleepInstr || !keyOk;
    assign ovf = keyOk && tick && !clrEvt && (cnt & lastCount(ctrl.sel)) == lastCount(ctrl.sel);
    assign ovfRun = ovf && !lowPower;
    assign ovfSleep = ovf && lowPower;
    assign fullRst = mmDone || ovfRun || lvDone;

    // Watchdog counter
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            cnt <= '0;
        end else if (clrEvt || fullRst || ovf) begin
            cnt <= '0;
        end else if (tick) begin
            cnt <= cnt + CNT_W'(1);
        end
    end

    // Control register, reloaded by every full reset
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            ctrl <= CTRL_RESET;
        end else if (fullRst) begin
            ctrl <= CTRL_RESET;
        end else if (wrLane && wrReq.addr == OFF_CTRL) begin
            ctrl <= wrReq.data[7:0];
        end
    end

    // Reset-cause flags, hardware set wins over software write
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            key_mismatch_reset_flag <= 1'b0;
            low_voltage_reset_flag <= 1'b0;
        end else begin
            if (mmDone) begin
                key_mismatch_reset_flag <= 1'b1;
            end else if (wrLane && wrReq.addr == OFF_CAUSE) begin
                key_mismatch_reset_flag <= wrReq.data[CAUSE_WRF];
            end
            if (lvDone) begin
                low_voltage_reset_flag <= 1'b1;
            end else if (wrLane && wrReq.addr == OFF_CAUSE) begin
                low_voltage_reset_flag <= wrReq.data[CAUSE_LOW_VOLTAGE_RESET_FLAG];
            end
        end
    end

    // Timeout, power-down and sleep state
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            toFlag <= 1'b0;
            power_down_flag <= 1'b0;
            lowPower <= 1'b0;
        end else begin
            if (ovf) begin
                toFlag <= 1'b1;
            end else if (sleepInstr) begin
                toFlag <= 1'b0;
            end
            if (sleepInstr) begin
                power_down_flag <= 1'b1;
            end else if (clrWdtInstr) begin
                power_down_flag <= 1'b0;
            end
            if (sleepInstr) begin
                lowPower <= 1'b1;
            end else if (wakeUp || ovfSleep || fullRst) begin
                lowPower <= 1'b0;
            end
        end
    end

    // Reset outputs, full reset held high through power-on
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            sysRst <= 1'b1;
            pcSpRst <= 1'b0;
        end else begin
            sysRst <= fullRst;
            pcSpRst <= ovfSleep;
        end
    end

    // Interrupt status, enable and level output
    always_comb begin
        next_irqStat = irqStat;
        if (wrLane && wrReq.addr == OFF_IRQ_CLR) begin
            next_irqStat = irqStat & ~wrReq.data[3:0];
        end
        next_irqStat[EVT_OVF] = next_irqStat[EVT_OVF] | ovf;
        next_irqStat[EVT_KEY] = next_irqStat[EVT_KEY] | mmDone;
        next_irqStat[EVT_LV] = next_irqStat[EVT_LV] | lvDone;
        next_irqStat[EVT_W] = next_irqStat[EVT_W] | ovfSleep;
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            irqStat <= '0;
            irqEn <= '0;
            irq <= 1'b0;
        end else begin
            irqStat <= next_irqStat;
            if (wrLane && wrReq.addr == OFF_IRQ_EN) begin
                irqEn <= wrReq.data[3:0];
            end
            irq <= |(next_irqStat & irqEn);
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstN);

    // Consecutive cycles with a bad key, for the delay check
    int badRun;
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            badRun <= 0;
        end else begin
            badRun <= (!keyOk && !fullRst) ? badRun + 1 : 0;
        end
    end

    sequence s_keyBad;
        !keyOk && !fullRst;
    endsequence

    sequence s_fullOut;
        sysRst && ctrl == CTRL_RESET && cnt == '0;
    endsequence

    a_key_enable: assert property (keyOk |-> !mmDone)
        else $error("key reset fired with a valid key");
    a_key_reset: assert property (mmDone |=> s_fullOut and key_mismatch_reset_flag)
        else $error("key mismatch did not give full reset");
    a_key_delay: assert property (s_keyBad ##1 mmDone |-> badRun == SRESET_DLY)
        else $error("key reset fired off the delay");
    a_ctrl_reset: assert property ($rose(rstN) |-> ctrl == CTRL_RESET && sysRst)
        else $error("control not at reset value after power-on");
    a_wrf_sticky: assert property (key_mismatch_reset_flag && !(wrLane && wrReq.addr == OFF_CAUSE) |=> key_mismatch_reset_flag)
        else $error("wrf cleared without software");
    a_ovf_normal: assert property (ovfRun |=> s_fullOut and toFlag)
        else $error("normal overflow did not reset");
    a_ovf_sleep: assert property (ovfSleep && !mmDone && !lvDone |=> pcSpRst && !sysRst && toFlag)
        else $error("sleep overflow handled wrongly");
    a_clear_count: assert property (clrWdtInstr || sleepInstr |=> cnt == '0)
        else $error("counter not cleared");
    a_count_limit: assert property (keyOk && cnt <= lastCount(ctrl.sel) && !(wrLane && wrReq.addr == OFF_CTRL)
        |=> cnt <= lastCount(ctrl.sel))
        else $error("counter beyond selected period");
    a_lvr_sleep: assert property (lowPower |-> !lvRun ##1 !lvDone)
        else $error("low-voltage reset active while asleep");
    a_lvr_reset: assert property (lvDone && !ovf && !sleepInstr |=> sysRst && low_voltage_reset_flag && $stable(toFlag))
        else $error("low-voltage reset not taken");
    a_cause_zero: assert property (rdAddr == OFF_CAUSE |-> rdData[31:3] == '0 && !rdData[1])
        else $error("reserved cause bits not zero");
    a_sleep_entry: assert property (sleepInstr && !ovf |=> power_down_flag && !toFlag && lowPower)
        else $error("sleep entry flags wrong");
    a_pdf_clear: assert property (clrWdtInstr && !sleepInstr |=> !power_down_flag)
        else $error("power-down flag not cleared");
endmodule // wdr_top

// File: pkg/wdr_pkg.sv
// Shared constants and types of the watchdog and reset-cause block
package wdr_pkg;
    // Clock and time figures
    localparam longint CLK_FREQ_HZ = 100_000_000;
    localparam longint LOW_SPEED_INTERNAL_OSCILLATOR_FREQ_HZ = 32_000;
    localparam int LOW_SPEED_INTERNAL_OSCILLATOR_DIV_CYC = int'(CLK_FREQ_HZ / LOW_SPEED_INTERNAL_OSCILLATOR_FREQ_HZ);
    localparam longint SRESET_DELAY_US = 50;
    localparam longint LVR_QUALIFY_US = 120;
    localparam int SRESET_CYC = int'((SRESET_DELAY_US * CLK_FREQ_HZ + 999_999) / 1_000_000);
    // Strictly longer than the qualify time, so one cycle beyond it
    localparam int LVR_QUAL_CYC = int'((LVR_QUALIFY_US * CLK_FREQ_HZ + 999_999) / 1_000_000) + 1;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CAUSE = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
    localparam logic [7:0] OFF_IRQ_EN = 8'h14;
    // Field values and positions
    localparam logic [4:0] KEY_A = 5'h0a;
    localparam logic [4:0] KEY_B = 5'h15;
    localparam logic [7:0] CTRL_RESET = 8'h53;
    localparam int CAUSE_WRF = 0;
    localparam int CAUSE_LOW_VOLTAGE_RESET_FLAG = 2;
    localparam int STAT_TO = 0;
    localparam int STAT_PDF = 1;
    localparam int STAT_SLEEP = 2;
    localparam int EVT_OVF = 0;
    localparam int EVT_KEY = 1;
    localparam int EVT_LV = 2;
    localparam int EVT_W = 3;
    localparam int CNT_W = 18;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [4:0] key;
        logic [2:0] sel;
    } wdr_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wdr_regwr_t;
endpackage
